// File: src/option_byte_config.sv
// Purpose: Non-volatile option byte store with programming-mode access and decode
// Assumes: Programming strobes are on core_clk; prog_mode_pin is asynchronous
// Notes:   Storage is modelled in flip-flops; por loads the blank or mask content
`timescale 1ns/1ps
`default_nettype none

// Contract
// - The option bytes have no processor address and are reachable only in programming mode.
// - Blank flash option bytes hold FFh.
// - interrupt_map_select 1 puts port A on vector a and ports B, C on vector b; 0 puts A, C on a.
// - readout_protect at 1 blocks external reads of program memory, at 0 allows them.
// - Clearing readout_protect erases all program memory and both option bytes to 00h.
// - clock_filter_off at 0 enables the clock filter and at 1 disables it.
// - osc_select picks external clock, internal RC, external RC or one of four resonators.
// - low_voltage_threshold 11 turns the detector off, else picks high, medium or low level.
// - watchdog_halt_reset at 1 resets on halt entry with watchdog active, at 0 it does not.
// - watchdog_soft_enable at 0 runs the watchdog from reset, at 1 waits for software.
// - Default content is FEh in byte zero and EFh in byte one.
// - In mask parts the option values are fixed and cannot be altered.
module option_byte_config
  import option_byte_pkg::*;
#(
  parameter bit         MASK_ROM   = 1'b0,
  parameter logic [7:0] MASK_BYTE0 = DEFAULT_B0,
  parameter logic [7:0] MASK_BYTE1 = DEFAULT_B1
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         por,
  input  wire logic         prog_mode_pin,
  input  wire logic         prog_wr,
  input  wire logic         prog_rd,
  input  wire logic         prog_sel,
  input  wire logic [7:0]   prog_wdata,
  output logic [7:0]        prog_rdata,
  output logic              prog_rvalid,
  output logic              prog_refused,
  output logic              mem_erase,
  output logic              ext_pm_rd_block,
  input  wire logic         halt_entry,
  input  wire logic         wdg_active,
  input  wire logic         watchdog_soft_enable_enable,
  output logic              halt_reset_req,
  output logic              wdg_run,
  output cfg_t              cfg
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helper

  // Turn the two raw bytes into the configuration fields
  function automatic cfg_t decode_cfg(input logic [7:0] b0, input logic [7:0] b1);
    cfg_t c;
    logic [2:0] osc;
    c   = '0;
    osc = b1[B1_OSC_HI:B1_OSC_LO];
    c.irq_map_select        = b0[B0_MAP_BIT];
    c.portc_on_vec_b        = b0[B0_MAP_BIT];
    c.readout_protect       = b0[B0_PROT_BIT];
    c.clock_filter_en       = ~b1[B1_CFOFF_BIT];
    case (osc)
      3'h7:    c.osc_select = OSC_EXT_CLOCK;
      3'h6:    c.osc_select = OSC_INT_RC;
      3'h5:    c.osc_select = OSC_EXT_RC;
      3'h4:    c.osc_select = OSC_EXT_RC;
      3'h3:    c.osc_select = OSC_LP;
      3'h2:    c.osc_select = OSC_MP;
      3'h1:    c.osc_select = OSC_MS;
      default: c.osc_select = OSC_HS;
    endcase
    c.low_voltage_threshold = lvd_t'(b1[B1_LVD_HI:B1_LVD_LO]);
    c.lvd_en                = (b1[B1_LVD_HI:B1_LVD_LO] != LVD_OFF);
    c.watchdog_halt_reset   = b1[B1_WHALT_BIT];
    c.watchdog_soft_enable  = b1[B1_WSW_BIT];
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Programming mode synchroniser

  logic sync1_ff;
  logic prog_mode_ff;

  // Two stages before any logic sees the pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_ff     <= 1'b0;
      prog_mode_ff <= 1'b0;
    end else begin
      sync1_ff     <= prog_mode_pin;
      prog_mode_ff <= sync1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Access qualification

  logic [7:0] nv_b0_ff;
  logic [7:0] nv_b1_ff;
  logic       acc_req;
  logic       wr_ok;
  logic       rd_ok;
  logic       clr_prot;

  // Only programming mode reaches the store; mask parts take no writes
  assign acc_req  = prog_wr | prog_rd;
  assign wr_ok    = prog_wr & prog_mode_ff & ~MASK_ROM & ~por;
  assign rd_ok    = prog_rd & ~prog_wr & prog_mode_ff & ~por;
  assign clr_prot = wr_ok & (prog_sel == SEL_BYTE0) & ~prog_wdata[B0_PROT_BIT]
                  & nv_b0_ff[B0_PROT_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Option byte storage

  // Power-on loads blank or mask content; writes land only in programming mode
  always_ff @(posedge core_clk) begin
    if (por) begin
      nv_b0_ff <= MASK_ROM ? MASK_BYTE0 : ERASED_BYTE;
      nv_b1_ff <= MASK_ROM ? MASK_BYTE1 : ERASED_BYTE;
    end else if (clr_prot) begin
      nv_b0_ff <= ERASE_VALUE;
      nv_b1_ff <= ERASE_VALUE;
    end else if (wr_ok) begin
      if (prog_sel == SEL_BYTE0) begin
        nv_b0_ff <= prog_wdata;                                        // Upper bits as given
      end else begin
        nv_b1_ff <= prog_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Programming answers

  // Read data, read strobe, refusal and erase pulse
  always_ff @(posedge core_clk) begin
    if (rst || por) begin
      prog_rdata   <= 8'h00;
      prog_rvalid  <= 1'b0;
      prog_refused <= 1'b0;
      mem_erase    <= 1'b0;
    end else begin
      prog_rvalid  <= rd_ok;
      if (rd_ok) begin
        prog_rdata <= (prog_sel == SEL_BYTE0) ? nv_b0_ff : nv_b1_ff;
      end
      prog_refused <= acc_req & ~wr_ok & ~rd_ok;
      mem_erase    <= clr_prot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read-out protection

  // Follows the stored bit one edge late, so an erase lifts it one edge after the store clears
  always_ff @(posedge core_clk) begin
    if (por) begin
      ext_pm_rd_block <= 1'b0;
    end else begin
      ext_pm_rd_block <= nv_b0_ff[B0_PROT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration latch

  // Sampled throughout reset, frozen once reset is released
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg <= decode_cfg(nv_b0_ff, nv_b1_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog and halt

  // Halt reset request and watchdog run level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      halt_reset_req <= 1'b0;
      wdg_run        <= 1'b0;
    end else begin
      halt_reset_req <= halt_entry & wdg_active & cfg.watchdog_halt_reset;
      wdg_run        <= ~cfg.watchdog_soft_enable | watchdog_soft_enable_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_REFUSE_OUTSIDE_PROG: assert property (
    (!prog_mode_ff && !por && acc_req) |=> (prog_refused && !prog_rvalid && !mem_erase))
    else $error("Access outside programming mode was not refused");

  AST_BLANK_CONTENT: assert property (disable iff (1'b0)
    (por && !MASK_ROM) |=> (nv_b0_ff == ERASED_BYTE && nv_b1_ff == ERASED_BYTE))
    else $error("Blank content is not all ones");

  AST_IRQ_MAP: assert property (disable iff (por)
    $fell(rst) |-> (cfg.portc_on_vec_b == $past(nv_b0_ff[B0_MAP_BIT])))
    else $error("Port C vector mapping wrong");

  AST_READOUT_BLOCK: assert property (disable iff (por)
    $rose(nv_b0_ff[B0_PROT_BIT]) |=> ext_pm_rd_block ##1 (ext_pm_rd_block || !nv_b0_ff[B0_PROT_BIT]))
    else $error("Read-out block did not follow protection bit");

  AST_ERASE_ON_CLEAR: assert property (disable iff (por)
    clr_prot |=> (mem_erase && nv_b0_ff == ERASE_VALUE && nv_b1_ff == ERASE_VALUE)
                 ##1 !ext_pm_rd_block)
    else $error("Clearing protection did not erase");

  AST_CLOCK_FILTER: assert property (disable iff (por)
    $fell(rst) |-> (cfg.clock_filter_en != $past(nv_b1_ff[B1_CFOFF_BIT])))
    else $error("Clock filter polarity wrong");

  AST_OSC_EXT_RC: assert property (disable iff (por)
    ($fell(rst) && $past(nv_b1_ff[B1_OSC_HI:B1_OSC_HI-1]) == 2'b10)
      |-> (cfg.osc_select == OSC_EXT_RC))
    else $error("External RC not selected");

  AST_LVD_OFF: assert property (disable iff (por)
    $fell(rst) |-> (cfg.lvd_en == ($past(nv_b1_ff[B1_LVD_HI:B1_LVD_LO]) != 2'h3)))
    else $error("Detector enable decode wrong");

  AST_HALT_RESET: assert property (
    (halt_entry && wdg_active) |=> (halt_reset_req == $past(cfg.watchdog_halt_reset)))
    else $error("Halt reset request wrong");

  AST_HW_WATCHDOG: assert property (
    (!cfg.watchdog_soft_enable && !$past(rst)) |-> wdg_run [*2])
    else $error("Hardware watchdog not running");

  AST_MASK_DEFAULT: assert property (disable iff (1'b0)
    (por && MASK_ROM) |=> (nv_b0_ff == MASK_BYTE0 && nv_b1_ff == MASK_BYTE1))
    else $error("Mask content not loaded");

  AST_MASK_FIXED: assert property (disable iff (por)
    (MASK_ROM && prog_wr) |=> ($stable(nv_b0_ff) && $stable(nv_b1_ff)))
    else $error("Mask option bytes changed");

  AST_CFG_HELD: assert property (
    !$past(rst) |-> $stable(cfg))
    else $error("Configuration changed outside reset");

endmodule

`default_nettype wire

// File: src/option_byte_pkg.sv
// Purpose: Shared constants and types for the option byte configuration store
// Assumes: Two 8-bit option bytes, byte select 0 or 1
// Notes:   Field positions, reset values and encodings live here only
package option_byte_pkg;

  localparam int          BYTE_W       = 8;
  localparam logic [7:0]  ERASED_BYTE  = 8'hFF;  // Blank flash content
  localparam logic [7:0]  ERASE_VALUE  = 8'h00;  // Content after protect removal
  localparam logic [7:0]  DEFAULT_B0   = 8'hFE;  // Factory default, byte zero
  localparam logic [7:0]  DEFAULT_B1   = 8'hEF;  // Factory default, byte one
  localparam logic        SEL_BYTE0    = 1'b0;
  localparam logic        SEL_BYTE1    = 1'b1;

  // Byte zero fields
  localparam int          B0_MAP_BIT   = 1;
  localparam int          B0_PROT_BIT  = 0;
  // Byte one fields
  localparam int          B1_CFOFF_BIT = 7;
  localparam int          B1_OSC_HI    = 6;
  localparam int          B1_OSC_LO    = 4;
  localparam int          B1_LVD_HI    = 3;
  localparam int          B1_LVD_LO    = 2;
  localparam int          B1_WHALT_BIT = 1;
  localparam int          B1_WSW_BIT   = 0;

  // Main clock source
  typedef enum logic [2:0] {
    OSC_EXT_CLOCK = 3'h7,
    OSC_INT_RC    = 3'h6,
    OSC_EXT_RC    = 3'h4,
    OSC_LP        = 3'h3,
    OSC_MP        = 3'h2,
    OSC_MS        = 3'h1,
    OSC_HS        = 3'h0
  } osc_src_t;

  // Low-voltage detector setting
  typedef enum logic [1:0] {
    LVD_OFF  = 2'h3,
    LVD_HIGH = 2'h2,
    LVD_MED  = 2'h1,
    LVD_LOW  = 2'h0
  } lvd_t;

  // Decoded configuration handed to clock, reset, watchdog and interrupt logic
  typedef struct packed {
    logic     irq_map_select;
    logic     portc_on_vec_b;   // 1: port C on second vector
    logic     readout_protect;
    logic     clock_filter_en;
    osc_src_t osc_select;
    logic     lvd_en;
    lvd_t     low_voltage_threshold;
    logic     watchdog_halt_reset;
    logic     watchdog_soft_enable;
  } cfg_t;

endpackage

// File: verif/prog_tool_model.sv
// Purpose: Programming tool model driving the option byte programming port
// Assumes: Strobe tasks are called by the bench; one strobe spans one taking edge
// Notes:   Released select and data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module prog_tool_model (
  input  wire logic       core_clk,
  output logic            prog_mode_pin,
  output logic            prog_wr,
  output logic            prog_rd,
  output logic            prog_sel,
  output logic [7:0]      prog_wdata
);
  // Idle lines at time zero
  initial begin
    prog_mode_pin = 1'b0;
    prog_wr       = 1'b0;
    prog_rd       = 1'b0;
    prog_sel      = 1'b0;
    prog_wdata    = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode pin; strobes are only meant for the device once it is set
  task automatic set_mode(input logic m);
    @(posedge core_clk);
    #1;
    prog_mode_pin = m;
  endtask

  // One write or read strobe, held over one edge, then lines released
  task automatic strobe(input logic wr, input logic sel, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    prog_wr    = wr;
    prog_rd    = !wr;
    prog_sel   = sel;
    prog_wdata = (wr && !sel) ? (d | 8'hFC) : d; // Reserved bits of byte zero at one
    @(posedge core_clk);
    #1;
    prog_wr    = 1'b0;
    prog_rd    = 1'b0;
    prog_sel   = ~prog_sel;
    prog_wdata = ~prog_wdata;
  endtask
endmodule
`default_nettype wire

// File: verif/option_byte_config_bench.sv
// Purpose: Self-checking bench for the option byte store and decode
// Assumes: Flash build, with a mask build on the same strobes; mode sync takes two edges
// Notes:   Expected decode is worked out from the field rules
`timescale 1ns/1ps
`default_nettype none
module option_byte_config_bench;
  import option_byte_pkg::*;
  logic       core_clk, rst, por, halt_entry, wdg_active, watchdog_soft_enable_enable;
  logic       prog_mode_pin, prog_wr, prog_rd, prog_sel, prog_rvalid, prog_refused;
  logic       mem_erase, ext_pm_rd_block, halt_reset_req, wdg_run, er, m_refused, m_block;
  logic [7:0] prog_wdata, prog_rdata, d0, d1, sb0, m_rdata;
  logic [31:0] r;
  cfg_t       cfg, exp, m_cfg;
  int         num_errors, checked, cycles;

  option_byte_config option_byte_config_i (.core_clk(core_clk), .rst(rst), .por(por),
    .prog_mode_pin(prog_mode_pin), .prog_wr(prog_wr), .prog_rd(prog_rd),
    .prog_sel(prog_sel), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
    .prog_rvalid(prog_rvalid), .prog_refused(prog_refused), .mem_erase(mem_erase),
    .ext_pm_rd_block(ext_pm_rd_block), .halt_entry(halt_entry), .wdg_active(wdg_active),
    .watchdog_soft_enable_enable(watchdog_soft_enable_enable), .halt_reset_req(halt_reset_req), .wdg_run(wdg_run),
    .cfg(cfg));
  prog_tool_model prog_tool_model_i (.core_clk(core_clk), .prog_mode_pin(prog_mode_pin),
    .prog_wr(prog_wr), .prog_rd(prog_rd), .prog_sel(prog_sel), .prog_wdata(prog_wdata));
  // Mask build on the same strobes; its content must never move
  option_byte_config #(.MASK_ROM(1'b1)) option_byte_config_rom_i (.core_clk(core_clk),
    .rst(rst), .por(por), .prog_mode_pin(prog_mode_pin), .prog_wr(prog_wr),
    .prog_rd(prog_rd), .prog_sel(prog_sel), .prog_wdata(prog_wdata), .prog_rdata(m_rdata),
    .prog_rvalid(), .prog_refused(m_refused), .mem_erase(), .ext_pm_rd_block(m_block),
    .halt_entry(halt_entry), .wdg_active(wdg_active), .watchdog_soft_enable_enable(watchdog_soft_enable_enable),
    .halt_reset_req(), .wdg_run(), .cfg(m_cfg));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      end_of_test();
    end
  end

  // Expected decode of the two bytes
  function automatic cfg_t dec(input logic [7:0] b0, input logic [7:0] b1);
    cfg_t c;
    c.irq_map_select        = b0[1];
    c.portc_on_vec_b        = b0[1];
    c.readout_protect       = b0[0];
    c.clock_filter_en       = !b1[7];
    c.osc_select            = (b1[6:5] == 2'b10) ? OSC_EXT_RC : osc_src_t'(b1[6:4]);
    c.lvd_en                = (b1[3:2] != 2'b11);
    c.low_voltage_threshold = lvd_t'(b1[3:2]);
    c.watchdog_halt_reset   = b1[1];
    c.watchdog_soft_enable  = b1[0];
    return c;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string msg);
    checked++;
    if (seen !== want) begin
      num_errors++;
      $display("ERROR %0t %s seen %h expected %h", $time, msg, seen, want);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    por = 1'b1;
    halt_entry = 1'b0;
    wdg_active = 1'b0;
    watchdog_soft_enable_enable = 1'b0;
    void'($urandom(3));
    repeat (3) @(posedge core_clk);
    #1;
    por = 1'b0;
    @(posedge core_clk);
    #1;
    rst = 1'b0;
    exp = dec(8'hFF, 8'hFF);
    sb0 = 8'hFF;
    check(16'(cfg), 16'(exp), "blank cfg");
    check(16'(ext_pm_rd_block), 16'h1, "protect");
    check(16'(m_cfg), 16'(dec(DEFAULT_B0, DEFAULT_B1)), "mask cfg");
    check(16'(m_block), 16'h0, "mask protect");
    prog_tool_model_i.strobe(1'b0, 1'b0, 8'h00);
    check(16'({prog_refused, prog_rvalid}), 16'h2, "outside mode");
    $display("test refusal done");
    prog_tool_model_i.set_mode(1'b1);
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 9; i++) begin
      r  = $urandom;
      d0 = (i == 8) ? 8'hFE : {6'h3F, r[9], (i != 0) & (i != 7) & r[8]};
      d1 = (i == 8) ? 8'hEF : {r[7], i[2:0], i[1:0], r[1:0]};
      er = sb0[0] & !d0[0];
      prog_tool_model_i.strobe(1'b1, 1'b0, d0);
      check(16'(mem_erase), 16'(er), "erase pulse");
      check(16'(m_refused), 16'h1, "mask write");
      sb0 = er ? 8'h00 : (d0 | 8'hFC);
      if (er) begin
        prog_tool_model_i.strobe(1'b0, 1'b1, 8'h00);
        check(16'(prog_rdata), 16'h0, "erased byte one");
      end
      prog_tool_model_i.strobe(1'b1, 1'b1, d1);
      prog_tool_model_i.strobe(1'b0, 1'b0, 8'h00);
      check(16'({prog_rvalid, prog_rdata}), {7'h0, 1'b1, sb0}, "read byte zero");
      check(16'(ext_pm_rd_block), 16'(sb0[0]), "protect");
      check(16'(m_rdata), 16'(DEFAULT_B0), "mask byte zero");
      prog_tool_model_i.strobe(1'b0, 1'b1, 8'h00);
      check(16'(prog_rdata), 16'(d1), "read byte one");
      check(16'(cfg), 16'(exp), "cfg held");
      @(posedge core_clk);
      #1;
      rst = 1'b1;
      @(posedge core_clk);
      #1;
      rst = 1'b0;
      halt_entry = 1'b1;
      wdg_active = r[20];
      watchdog_soft_enable_enable = r[21];
      exp = dec(sb0, d1);
      check(16'(cfg), 16'(exp), "cfg decode");
      check(16'(m_cfg), 16'(dec(DEFAULT_B0, DEFAULT_B1)), "mask cfg fixed");
      @(posedge core_clk);
      #1;
      halt_entry = 1'b0;
      check(16'(halt_reset_req), 16'(r[20] & d1[1]), "halt reset");
      check(16'(wdg_run), 16'(!d1[0] | r[21]), "watchdog run");
      @(posedge core_clk);
      $display("test config %0d done", i);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
